// ### rtl/bbds_defs.vh
// Constants for the descriptor byte store: layout, defaults and register map.
// Assumes inclusion by the single store module; definitions only.
`ifndef BBDS_DEFS_VH
`define BBDS_DEFS_VH

// Image geometry: 11 groups of four bytes
`define BBDS_NBYTES        44
`define BBDS_AW            6

// Byte positions inside the image
`define BBDS_POS_URL_IDX   6'd3
`define BBDS_POS_NUM_ALT   6'd4
`define BBDS_POS_PREF_ALT  6'd5
`define BBDS_POS_VCONN_LO  6'd6
`define BBDS_POS_VCONN_HI  6'd7
`define BBDS_POS_CFG_FIRST 6'd8
`define BBDS_POS_CFG_LAST  6'd39
`define BBDS_POS_VER_LO    6'd40
`define BBDS_POS_VER_HI    6'd41
`define BBDS_POS_FAIL_INFO 6'd42
`define BBDS_POS_RSVD      6'd43
`define BBDS_POS_SVID_LO   6'd44
`define BBDS_POS_SVID_HI   6'd45
`define BBDS_POS_ALT_MODE  6'd46
`define BBDS_LAST_POS      6'd46

// Reset values
`define BBDS_RST_URL_IDX   8'h01
`define BBDS_RST_NUM_ALT   8'h01
`define BBDS_RST_PREF_ALT  8'h00
`define BBDS_RST_VCONN_LO  8'h00
`define BBDS_RST_VCONN_HI  8'h80
`define BBDS_RST_CFG       8'h00
`define BBDS_RST_VER_LO    8'h10
`define BBDS_RST_VER_HI    8'h01
`define BBDS_RST_FAIL_INFO 8'h00
`define BBDS_RST_SVID_LO   8'h00
`define BBDS_RST_SVID_HI   8'hff
`define BBDS_RST_ZERO      8'h00
`define BBDS_RST_ALT_STR   8'h00

// APB register byte addresses
`define BBDS_REG_IMG_BASE  12'h000
`define BBDS_REG_ALT_STR   12'h0c0
`define BBDS_REG_STATUS    12'h0c4
`define BBDS_REG_RD_PTR    12'h0c8

`endif

// ### rtl/bbds_store.v
// Descriptor byte store: the capability image, the two string indices,
// an APB slave for loading and a byte-serial read port for the host side.
// Assumes one clock, synchronous inputs and a host-facing engine that
// pulses rd_start and then takes bytes with rd_next.
// Assumes clk_en is held high while the loader works the bus: with it
// low every register except timer_b_start holds (that pulse is cleared) and bus writes are dropped without an error.
//
// Chosen here: the APB register port and the register addresses.
`include "bbds_defs.vh"

// Behaviour
// - Both string indices writable by configuration loader
// - Image laid out as four-byte groups, order
// - Mode count one, preferred index zero
// - VCONN power defaults 00h then 80h
// - All 32 configured bytes reset zero
// - Class version defaults 10h then 01h
// - Failure info and reserved reset zero
// - SVID 00h FFh, alternate mode zero
// - URL index at group offset three defaults one
// - Configured entries default to unspecified error
// - Mode string request returns index, starts timer
module bbds_store (
    // Clock, reset, enable
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    // Host-side descriptor readout
    input  wire        rd_start,
    input  wire        rd_next,
    output reg  [7:0]  rd_byte,
    output reg         rd_valid,
    output reg         rd_last,
    // Alternate-mode string request
    input  wire        alt_str_req,
    output reg  [7:0]  alt_str_idx,
    output reg         timer_b_start
);

    // Image storage: positions 0..2 unused and read zero. A full array is
    // kept rather than a flat vector so the readout can index it directly;
    // the cost is wide read muxes, four lanes for the bus and one more for the readout.
    reg  [7:0]  img_q [0:`BBDS_LAST_POS];  // Descriptor bytes
    reg  [7:0]  alt_str_q;                 // Mode string index
    reg  [5:0]  rd_ptr_q;                  // Readout position
    reg         rd_busy_q;                 // Readout in progress
    reg  [15:0] req_cnt_q;                 // String requests seen

    // Default value of one image byte. Kept as a function so that every
    // slice's reset branch sees a constant, and a changed default is made
    // in one place only.
    function [7:0] bbds_default;
        input [5:0] pos;
        begin
            // Positions 0..2 also land on the default branch and stay zero
            case (pos)
                `BBDS_POS_URL_IDX:   bbds_default = `BBDS_RST_URL_IDX;
                `BBDS_POS_NUM_ALT:   bbds_default = `BBDS_RST_NUM_ALT;
                `BBDS_POS_PREF_ALT:  bbds_default = `BBDS_RST_PREF_ALT;
                `BBDS_POS_VCONN_LO:  bbds_default = `BBDS_RST_VCONN_LO;
                `BBDS_POS_VCONN_HI:  bbds_default = `BBDS_RST_VCONN_HI;
                `BBDS_POS_VER_LO:    bbds_default = `BBDS_RST_VER_LO;
                `BBDS_POS_VER_HI:    bbds_default = `BBDS_RST_VER_HI;
                `BBDS_POS_FAIL_INFO: bbds_default = `BBDS_RST_FAIL_INFO;
                `BBDS_POS_RSVD:      bbds_default = `BBDS_RST_ZERO;
                `BBDS_POS_SVID_LO:   bbds_default = `BBDS_RST_SVID_LO;
                `BBDS_POS_SVID_HI:   bbds_default = `BBDS_RST_SVID_HI;
                `BBDS_POS_ALT_MODE:  bbds_default = `BBDS_RST_ZERO;
                // Configured array: 00b per entry means unspecified error
                default:             bbds_default = `BBDS_RST_CFG;
            endcase
        end
    endfunction

    // Bus decode: access phase, write strobe and the image window
    wire        acc    = psel & penable;          // Access phase of a transfer
    wire        wr_acc = acc & pwrite & clk_en;   // A write lands at this edge
    wire        in_img = (paddr < (`BBDS_REG_IMG_BASE + 12'd48)) && (paddr[1:0] == 2'b00);
    wire [5:0]  grp    = {paddr[5:2], 2'b00};     // First image position of the word

    // Word registers outside the image; each compare feeds the error
    // decode and the read mux, and hit_alt the write path too, so it is made once here
    wire        hit_alt  = (paddr == `BBDS_REG_ALT_STR);  // Mode string index
    wire        hit_stat = (paddr == `BBDS_REG_STATUS);   // Status, read only
    wire        hit_ptr  = (paddr == `BBDS_REG_RD_PTR);   // Readout pointer, read only
    wire        mapped   = in_img || hit_alt || hit_stat || hit_ptr;

    // Zero-wait slave; unmapped or misaligned addresses error. The error
    // is combinational off the access phase, so it stands exactly as long
    // as penable does and a setup cycle never shows a stale error.
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    // Image bytes: one generate slice per position, byte lanes per strobe.
    // Each slice owns one byte, so a strobe on one lane never disturbs its
    // neighbours. Positions 0..2 are never written: they are padding in
    // the first word, and the write guard keeps them at zero for good.
    genvar gi;
    generate
        for (gi = 0; gi <= `BBDS_LAST_POS; gi = gi + 1) begin : g_byte
            // Position, lane and word of this slice, cut to the widths that
            // they are compared with so that no compare pads or drops bits
            localparam [31:0] POS_W = gi;            // Loop index as a plain word
            localparam [5:0]  POS   = POS_W[5:0];    // Image position
            localparam [1:0]  LANE  = POS_W[1:0];    // Byte lane within its word
            localparam [5:0]  WORD  = POS & 6'h3c;   // First position of its word
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    // Reset loads a constant: the default of this position
                    img_q[gi] <= bbds_default(POS);
                end else if (wr_acc && in_img && (grp == WORD)
                             && pstrb[LANE] && (POS >= `BBDS_POS_URL_IDX)) begin
                    // Group layout: lane n of word k is byte 4k+n
                    img_q[gi] <= pwdata[LANE*8 +: 8];
                end
            end
        end
    endgenerate

    // Mode string index register. Only lane 0 is stored; the upper lanes
    // read back zero, so a loader that writes a full word cannot plant
    // stray bits that a later readback would mistake for a setting.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_str_q <= `BBDS_RST_ALT_STR;
        end else if (wr_acc && hit_alt && pstrb[0]) begin
            alt_str_q <= pwdata[7:0];
        end
    end

    // Read data mux, registered so data outputs come from flip-flops.
    // Loading in the setup cycle costs no wait state: a write in the
    // transfer before has landed one edge earlier, so a read straight
    // after it already returns the new bytes.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en && psel && !penable && !pwrite) begin
            // Captured in the setup cycle, valid through the access cycle
            if (in_img) begin
                // Positions below 3 and above 46 read as zero
                prdata <= {(grp + 6'd3 <= `BBDS_LAST_POS) ? img_q[grp + 6'd3] : 8'h00,
                           (grp + 6'd2 <= `BBDS_LAST_POS) ? img_q[grp + 6'd2] : 8'h00,
                           (grp + 6'd1 <= `BBDS_LAST_POS) ? img_q[grp + 6'd1] : 8'h00,
                           (grp >= 6'd3) ? img_q[grp] : 8'h00};
            end else if (hit_alt) begin
                prdata <= {24'h000000, alt_str_q};
            end else if (hit_stat) begin
                // Request count above, busy flag in bit 0
                prdata <= {req_cnt_q, 15'h0000, rd_busy_q};
            end else if (hit_ptr) begin
                prdata <= {26'h0000000, rd_ptr_q};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Ordered readout of the image from position 3 upward. rd_start wins
    // over rd_next, so a host that restarts in mid-descriptor always sees
    // the first byte again. The pointer runs one position ahead of the
    // byte on rd_byte, which keeps the array read out of the output path.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ptr_q  <= 6'd0;
            rd_busy_q <= 1'b0;
            rd_byte   <= 8'h00;
            rd_valid  <= 1'b0;
            rd_last   <= 1'b0;
        end else if (clk_en) begin
            if (rd_start) begin
                // A new request restarts from the first byte
                rd_ptr_q  <= `BBDS_POS_URL_IDX + 6'd1;
                rd_busy_q <= 1'b1;
                rd_byte   <= img_q[`BBDS_POS_URL_IDX];
                rd_valid  <= 1'b1;
                rd_last   <= 1'b0;
            end else if (rd_busy_q && rd_next) begin
                // A stray rd_next with no readout running is simply ignored
                if (rd_last) begin
                    // Final byte consumed
                    rd_busy_q <= 1'b0;
                    rd_valid  <= 1'b0;
                    rd_last   <= 1'b0;
                end else begin
                    // Show the next byte and flag it if it is the final one
                    rd_byte  <= img_q[rd_ptr_q];
                    rd_last  <= (rd_ptr_q == `BBDS_LAST_POS);
                    rd_ptr_q <= rd_ptr_q + 6'd1;
                end
            end
        end
    end

    // String request: hand back the index and pulse the timer start.
    // The pulse follows the request one cycle later and lasts as long as
    // the request did. The request count is 16 bits and wraps silently;
    // it is a debug aid, not a limit the host side relies on.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // No pulse and no index until the host first asks
            alt_str_idx   <= 8'h00;
            timer_b_start <= 1'b0;
            req_cnt_q     <= 16'h0000;
        end else if (clk_en) begin
            // Follows the request every enabled cycle, so the pulse self-clears
            timer_b_start <= alt_str_req;
            if (alt_str_req) begin
                alt_str_idx <= alt_str_q;
                req_cnt_q   <= req_cnt_q + 16'h0001;
            end
        end else begin
            // A frozen cycle must not stretch the pulse
            timer_b_start <= 1'b0;
        end
    end

endmodule

// ### tb/bbds_store_sva.sv
// Port checker for the descriptor store.
// Assumes a bind onto bbds_store; single clock, async active-low reset.
module bbds_store_sva (
    // Clock, reset, enable
    input logic        pclk,
    input logic        presetn,
    input logic        clk_en,
    // APB
    input logic        psel,
    input logic        penable,
    input logic [11:0] paddr,
    input logic        pready,
    input logic        pslverr,
    // Readout and string request
    input logic        rd_start,
    input logic        rd_next,
    input logic        rd_valid,
    input logic        rd_last,
    input logic        alt_str_req,
    input logic        timer_b_start
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_always: assert property (psel |-> pready) else $error("pready low");
    a_bad_addr: assert property (psel && penable && paddr > 12'h0c8 |-> pslverr)
        else $error("no slverr");
    a_img_ok: assert property (psel && penable && paddr < 12'h030 && paddr[1:0] == 2'b00
        |-> !pslverr) else $error("image slverr");
    a_start_valid: assert property (rd_start && clk_en |=> rd_valid && !rd_last)
        else $error("no first byte");
    a_start_run: assert property (rd_start && clk_en |=> (!rd_last) [*8])
        else $error("early last");
    a_last_drop: assert property (rd_last && rd_next && clk_en && !rd_start |=> !rd_valid)
        else $error("valid after last");
    a_timer_pulse: assert property (alt_str_req && clk_en |=> timer_b_start)
        else $error("no timer pulse");
    a_timer_cause: assert property (timer_b_start |-> $past(alt_str_req))
        else $error("stray timer pulse");
    // Main scenarios reached
    c_last: cover property (rd_last && rd_next);
    c_timer: cover property (timer_b_start);
    c_err: cover property (psel && penable && pslverr);
    c_freeze: cover property (alt_str_req && !clk_en);
endmodule

// ### tb/bbds_host_model.sv
// Host-side reader: restarts readout, then takes bytes one by one.
// Assumes the store's readout handshake; gap slows the reader.
module bbds_host_model (
    input  logic       pclk,
    input  logic [7:0] rd_byte,
    input  logic       rd_valid,
    output logic       rd_start,
    output logic       rd_next
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] q[$]; // Bytes seen in order
    initial {rd_start, rd_next} = 2'b00;
    // Reads until valid drops; bounded so a stuck valid cannot hang
    task automatic read_desc(input int gap);
        q.delete();
        @(posedge pclk) rd_start <= 1'b1;
        @(posedge pclk) rd_start <= 1'b0;
        repeat (60) begin
            @(posedge pclk);
            repeat (gap) @(posedge pclk);
            if (rd_valid !== 1'b1) break;
            q.push_back(rd_byte);
            rd_next <= 1'b1;
            @(posedge pclk) rd_next <= 1'b0;
        end
    endtask
endmodule

// ### tb/tb.sv
// Testbench for the descriptor store: APB loader, host reader, checks.
// Assumes the store, checker and host model are compiled before it.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, clk_en, psel, penable, pwrite, alt_str_req, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic [3:0]  pstrb;
    wire  [31:0] prdata;
    wire  [7:0]  rd_byte, alt_str_idx;
    wire         pready, pslverr, rd_valid, rd_last, timer_b_start, rd_start, rd_next;
    int          failures, total_checks;
    // Default image: position in the upper byte, value in the lower
    logic [15:0] rows [14] = '{16'h0301, 16'h0401, 16'h0500, 16'h0600, 16'h0780, 16'h0800,
        16'h2700, 16'h2810, 16'h2901, 16'h2a00, 16'h2b00, 16'h2c00, 16'h2dff, 16'h2e00};
    bbds_store i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .rd_start(rd_start),
        .rd_next(rd_next), .rd_byte(rd_byte), .rd_valid(rd_valid), .rd_last(rd_last),
        .alt_str_req(alt_str_req), .alt_str_idx(alt_str_idx), .timer_b_start(timer_b_start));
    bbds_host_model i_host (.pclk(pclk), .rd_byte(rd_byte), .rd_valid(rd_valid),
        .rd_start(rd_start), .rd_next(rd_next));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        #400000;
        failures++;
        end_of_test;
    end
    initial begin
        {presetn, psel, penable, pwrite, alt_str_req, paddr, pwdata, pstrb} = '0;
        clk_en = 1'b1;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        i_host.read_desc(0);
        chk(i_host.q.size(), 44);
        foreach (rows[i]) chk(i_host.q[rows[i][15:8] - 3], rows[i][7:0]);
        apb(0, 12'h004, 0, 0);
        chk(rd, 32'h80000001);
        apb(0, 12'h028, 0, 0);
        chk(rd, 32'h00000110);
        // URL index lane and a partial configured word
        apb(1, 12'h000, 32'h55000000, 4'h8);
        apb(1, 12'h008, 32'hddccbbaa, 4'h5);
        apb(0, 12'h008, 0, 0);
        chk(rd, 32'h00cc00aa);
        i_host.read_desc(2);
        chk(i_host.q[0], 8'h55);
        chk(i_host.q[7], 8'hcc);
        apb(0, 12'h100, 0, 0);
        chk(err, 1);
        apb(1, 12'h0c0, 32'h2a, 4'hf);
        @(posedge pclk) alt_str_req <= 1'b1;
        @(posedge pclk) alt_str_req <= 1'b0;
        #1 chk(timer_b_start, 1);
        chk(alt_str_idx, 8'h2a);
        // Frozen clock enable: a request must neither pulse nor count
        @(posedge pclk) begin
            clk_en <= 1'b0;
            alt_str_req <= 1'b1;
        end
        @(posedge pclk) alt_str_req <= 1'b0;
        #1 chk(timer_b_start, 0);
        @(posedge pclk) clk_en <= 1'b1;
        apb(0, 12'h0c4, 0, 0);
        chk(rd, 32'h00010000);
        apb(0, 12'h0c0, 0, 0);
        chk(rd, 32'h0000002a);
        // Reset in mid-run brings the defaults back
        @(posedge pclk) presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 12'h000, 0, 0);
        chk(rd[31:24], 8'h01);
        apb(0, 12'h008, 0, 0);
        chk(rd, 0);
        end_of_test;
    end
endmodule
bind bbds_store bbds_store_sva i_sva (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .rd_start(rd_start), .rd_next(rd_next), .rd_valid(rd_valid), .rd_last(rd_last),
    .alt_str_req(alt_str_req), .timer_b_start(timer_b_start));
